// ==== esm_consts.svh ====
// esm_consts.svh: offsets, codes and timing counts of the EDID source manager
// assumes a 100 MHz sys_clk_in; included by bare name
`ifndef ESM_CONSTS_SVH
`define ESM_CONSTS_SVH

`define ESM_DDC_ADDR 8'hA0
`define ESM_EDID_LAST 8'hFF
`define ESM_LOC_EEP_BYTES 32768
`define ESM_CLK_NS 10
`define ESM_BC_TMO_5M_NS 20000
`define ESM_BC_TMO_20M_NS 5000
`define ESM_RETRY_NS 100000
`define ESM_BC_TMO_5M_CYC ((`ESM_BC_TMO_5M_NS + `ESM_CLK_NS - 1) / `ESM_CLK_NS)
`define ESM_BC_TMO_20M_CYC ((`ESM_BC_TMO_20M_NS + `ESM_CLK_NS - 1) / `ESM_CLK_NS)
`define ESM_RETRY_CYC ((`ESM_RETRY_NS + `ESM_CLK_NS - 1) / `ESM_CLK_NS)
`define ESM_PIN_RST 6'h07
`define ESM_BOOT_LAST 3'h5
`define ESM_STRAP_CAP 3'h4

`endif

// ==== esm_pkg.sv ====
// esm_pkg.sv: types of the EDID source manager
// assumes nothing beyond a SystemVerilog compiler
package esm_pkg;

  typedef enum logic [1:0] {
    ESM_SRC_LOCAL = 2'h0,
    ESM_SRC_SRAM = 2'h1,
    ESM_SRC_REMOTE = 2'h2,
    ESM_SRC_FUSE = 2'h3
  } esm_src_e;

  typedef enum logic [6:0] {
    ESM_ST_BOOT = 7'h01,
    ESM_ST_FUSE_RD = 7'h02,
    ESM_ST_FUSE_WR = 7'h04,
    ESM_ST_REM_REQ = 7'h08,
    ESM_ST_REM_WAIT = 7'h10,
    ESM_ST_REM_HOLD = 7'h20,
    ESM_ST_READY = 7'h40
  } esm_mgr_e;

  typedef enum logic [6:0] {
    ESM_SL_IDLE = 7'h01,
    ESM_SL_ADDR = 7'h02,
    ESM_SL_ACK_A = 7'h04,
    ESM_SL_WR = 7'h08,
    ESM_SL_ACK_W = 7'h10,
    ESM_SL_RD = 7'h20,
    ESM_SL_ACK_R = 7'h40
  } esm_slv_e;

endpackage : esm_pkg

// ==== esm_core_if.sv ====
// esm_core_if.sv: links the manager, the EDID store and the DDC slave
// assumes all three sit on sys_clk_in
`timescale 1ns/1ps

interface esm_core_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] ddc_addr;
  logic [7:0] ddc_data;
  logic [7:0] hst_addr;
  logic [7:0] hst_data;
  logic scl;
  logic sda;
  logic slv_en;
  logic match_any;
  logic sda_low;
  logic turn;

  modport mgr (output wr_en, wr_addr, wr_data, hst_addr, scl, sda, slv_en, match_any,
    input hst_data, sda_low, turn);
  modport ram (input wr_en, wr_addr, wr_data, ddc_addr, hst_addr, output ddc_data, hst_data);
  modport slv (input scl, sda, slv_en, match_any, ddc_data, output ddc_addr, sda_low, turn);
endinterface : esm_core_if

// ==== esm_edid_ram.sv ====
// esm_edid_ram.sv: volatile EDID store, one write port, two registered read ports
// assumes the writer arbitrates; contents undefined until loaded
`timescale 1ns/1ps

module esm_edid_ram #(
  parameter int DEPTH = 256
) (
  input wire logic sys_clk_in,
  esm_core_if.ram mem
);

  logic [7:0] store [DEPTH];

  always_ff @(posedge sys_clk_in) begin
    if (mem.wr_en) begin
      store[mem.wr_addr] <= mem.wr_data;
    end
    mem.ddc_data <= store[mem.ddc_addr];
    mem.hst_data <= store[mem.hst_addr];
  end

endmodule : esm_edid_ram

// ==== esm_ddc_slave.sv ====
// esm_ddc_slave.sv: DDC I2C slave tracking bus phases and serving store bytes
// assumes scl and sda already synchronised and filtered, line levels as seen on the wire
`timescale 1ns/1ps
`include "esm_consts.svh"

module esm_ddc_slave (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  esm_core_if.slv bus
);

  localparam logic [7:0] DEV_ADDR = `ESM_DDC_ADDR;

  esm_pkg::esm_slv_e st_ff, nxt_st;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] sh_ff, nxt_sh;
  logic [7:0] tx_ff, nxt_tx;
  logic [7:0] off_ff, nxt_off;
  logic rw_ff, nxt_rw;
  logic first_ff, nxt_first;
  logic scl_d_ff;
  logic sda_d_ff;

  wire scl_rise = bus.scl & ~scl_d_ff;
  wire scl_fall = ~bus.scl & scl_d_ff;
  wire start_det = bus.scl & scl_d_ff & sda_d_ff & ~bus.sda;
  wire stop_det = bus.scl & scl_d_ff & ~sda_d_ff & bus.sda;
  wire byte_done = (cnt_ff == 4'h8);
  wire addr_hit = bus.match_any | (sh_ff[7:1] == DEV_ADDR[7:1]);

  // *****************************
  // protocol tracking
  // *****************************
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_tx = tx_ff;
    nxt_off = off_ff;
    nxt_rw = rw_ff;
    nxt_first = first_ff;
    if (!bus.slv_en) begin
      nxt_st = esm_pkg::ESM_SL_IDLE;
    end else if (start_det) begin
      nxt_st = esm_pkg::ESM_SL_ADDR;
      nxt_cnt = 4'h0;
    end else if (stop_det) begin
      nxt_st = esm_pkg::ESM_SL_IDLE;
    end else if (scl_rise) begin
      nxt_sh = {sh_ff[6:0], bus.sda};
      nxt_cnt = cnt_ff + 4'h1;
    end else if (scl_fall) begin
      unique case (st_ff)
        esm_pkg::ESM_SL_IDLE: begin
        end
        esm_pkg::ESM_SL_ADDR: begin
          if (byte_done) begin
            nxt_rw = sh_ff[0];
            nxt_st = addr_hit ? esm_pkg::ESM_SL_ACK_A : esm_pkg::ESM_SL_IDLE;
          end
        end
        esm_pkg::ESM_SL_ACK_A: begin
          nxt_cnt = 4'h0;
          nxt_first = 1'b1;
          nxt_tx = bus.ddc_data;
          nxt_st = rw_ff ? esm_pkg::ESM_SL_RD : esm_pkg::ESM_SL_WR;
        end
        esm_pkg::ESM_SL_WR: begin
          if (byte_done) begin
            nxt_st = esm_pkg::ESM_SL_ACK_W;
            nxt_first = 1'b0;
            if (first_ff) begin
              nxt_off = sh_ff;
            end
          end
        end
        esm_pkg::ESM_SL_ACK_W: begin
          nxt_cnt = 4'h0;
          nxt_st = esm_pkg::ESM_SL_WR;
        end
        esm_pkg::ESM_SL_RD: begin
          if (byte_done) begin
            nxt_st = esm_pkg::ESM_SL_ACK_R;
            nxt_off = off_ff + 8'h01;
          end else begin
            nxt_tx = {tx_ff[6:0], 1'b1};
          end
        end
        esm_pkg::ESM_SL_ACK_R: begin
          nxt_cnt = 4'h0;
          nxt_tx = bus.ddc_data;
          nxt_st = sh_ff[0] ? esm_pkg::ESM_SL_IDLE : esm_pkg::ESM_SL_RD;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st_ff <= esm_pkg::ESM_SL_IDLE;
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      tx_ff <= 8'hFF;
      off_ff <= 8'h00;
      rw_ff <= 1'b0;
      first_ff <= 1'b0;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      tx_ff <= nxt_tx;
      off_ff <= nxt_off;
      rw_ff <= nxt_rw;
      first_ff <= nxt_first;
      scl_d_ff <= bus.scl;
      sda_d_ff <= bus.sda;
    end
  end

  wire ack_slot = (st_ff == esm_pkg::ESM_SL_ACK_A) | (st_ff == esm_pkg::ESM_SL_ACK_W);
  wire rd_slot = (st_ff == esm_pkg::ESM_SL_RD);

  assign bus.turn = ack_slot | rd_slot;
  assign bus.sda_low = bus.slv_en & (ack_slot | (rd_slot & ~tx_ff[7]));
  assign bus.ddc_addr = off_ff;

endmodule : esm_ddc_slave

// ==== esm_edid_mgr.sv ====
// esm_edid_mgr.sv: EDID source manager, top of the block
// assumes fuse macro, back-channel transport and register file outside on sys_clk_in
// How it works
// - DDC slave answers at address 0xA0 in SRAM, remote and fuse modes; in local mode it tracks every address.
// - Source comes from strap pins, or from the override control when enabled.
// - Local EEPROM mode bridges DDC to the EEPROM, so any size up to 32KB works.
// - 256-byte volatile store; in SRAM mode an outside master loads it before use.
// - Store can be rewritten through the host port while hst_ready_out is high, and read back anytime.
// - Remote mode reads address 0xA0 over the back channel on its own.
// - Once the remote EEPROM answers, all 256 bytes are copied into the store.
// - Fuse mode copies the 256-byte fused image into the store at start-up.
// - Fuse mode serves DDC reads from the store holding that image.
// - Hot-plug held low until ready with +5 V present, then released to the pull-up.
// - Back-channel frames carry I2C, CRC and 4 GPIO bits at 5 or 20 Mbps.
`timescale 1ns/1ps
`include "esm_consts.svh"

module esm_edid_mgr #(
  parameter int unsigned RETRY_CYC = `ESM_RETRY_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic pwr5v_in,
  output logic hpd_out,
  output logic hpd_oe_out,
  input wire logic ddc_scl_in,
  input wire logic ddc_sda_in,
  output logic ddc_sda_out,
  output logic ddc_sda_oe_out,
  output logic eep_scl_out,
  output logic eep_scl_oe_out,
  input wire logic eep_sda_in,
  output logic eep_sda_out,
  output logic eep_sda_oe_out,
  input wire logic [1:0] src_strap_in,
  input wire logic src_ovr_en_in,
  input wire logic [1:0] src_ovr_in,
  input wire logic hst_wr_in,
  input wire logic hst_rd_in,
  input wire logic [7:0] hst_addr_in,
  input wire logic [7:0] hst_wdata_in,
  input wire logic hst_load_done_in,
  output logic hst_ready_out,
  output logic [7:0] hst_rdata_out,
  output logic hst_rvalid_out,
  output logic [7:0] fuse_addr_out,
  input wire logic [7:0] fuse_data_in,
  output logic bc_req_valid_out,
  input wire logic bc_req_ready_in,
  output logic [7:0] bc_req_dev_out,
  output logic [7:0] bc_req_off_out,
  input wire logic bc_rsp_valid_in,
  input wire logic bc_rsp_nack_in,
  input wire logic [7:0] bc_rsp_data_in,
  input wire logic bc_frm_valid_in,
  input wire logic bc_frm_crc_err_in,
  input wire logic [3:0] bc_frm_gpio_in,
  input wire logic bc_fast_in,
  output logic [3:0] gpio_out,
  output logic [1:0] src_mode_out,
  output logic edid_ready_out
);

  localparam int PIN_W = 6;
  localparam logic [7:0] LAST_IDX = `ESM_EDID_LAST;

  // *****************************
  // pin synchronisers
  // *****************************
  // bit order: strap[1:0], pwr5v, eep sda, ddc sda, ddc scl
  logic [PIN_W-1:0] s1_ff;
  logic [PIN_W-1:0] s2_ff;
  logic [PIN_W-1:0] s3_ff;
  logic [PIN_W-1:0] lvl_ff;
  wire [PIN_W-1:0] pin_raw = {src_strap_in, pwr5v_in, eep_sda_in, ddc_sda_in, ddc_scl_in};
  wire [PIN_W-1:0] nxt_lvl = (s2_ff & s3_ff) | (lvl_ff & ~(s2_ff ^ s3_ff));

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      s1_ff <= `ESM_PIN_RST;
      s2_ff <= `ESM_PIN_RST;
      s3_ff <= `ESM_PIN_RST;
      lvl_ff <= `ESM_PIN_RST;
    end else begin
      s1_ff <= pin_raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end

  wire scl_lvl = lvl_ff[0];
  wire sda_lvl = lvl_ff[1];
  wire eep_sda_lvl = lvl_ff[2];
  wire pwr_lvl = lvl_ff[3];

  // *****************************
  // source selection
  // *****************************
  logic [2:0] boot_cnt_ff;
  logic [1:0] strap_ff;
  esm_pkg::esm_src_e mode_ff;
  esm_pkg::esm_src_e nxt_mode;
  esm_pkg::esm_mgr_e st_ff;
  esm_pkg::esm_mgr_e nxt_st;

  wire boot_done = (boot_cnt_ff == `ESM_BOOT_LAST);
  wire [1:0] sel_raw = src_ovr_en_in ? src_ovr_in : strap_ff;
  wire esm_pkg::esm_src_e sel_mode = esm_pkg::esm_src_e'(sel_raw);
  wire mode_chg = (st_ff != esm_pkg::ESM_ST_BOOT) & (sel_mode != mode_ff);
  wire is_local = (mode_ff == esm_pkg::ESM_SRC_LOCAL);

  // strap caught once the filtered level has settled, one cycle before boot ends
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      boot_cnt_ff <= 3'h0;
      strap_ff <= 2'h0;
    end else begin
      if (!boot_done) begin
        boot_cnt_ff <= boot_cnt_ff + 3'h1;
      end
      if (boot_cnt_ff == `ESM_STRAP_CAP) begin
        strap_ff <= lvl_ff[5:4];
      end
    end
  end

  // *****************************
  // copy engine
  // *****************************
  logic [7:0] idx_ff;
  logic [7:0] nxt_idx;
  logic [15:0] wait_ff;
  logic [15:0] nxt_wait;
  logic loaded_ff;

  wire [15:0] tmo_lim = bc_fast_in ? 16'(`ESM_BC_TMO_20M_CYC) : 16'(`ESM_BC_TMO_5M_CYC);
  wire [15:0] hold_lim = 16'(RETRY_CYC - 1);
  wire rsp_good = bc_rsp_valid_in & ~bc_rsp_nack_in & ~bc_frm_crc_err_in;
  wire rsp_bad = bc_rsp_valid_in & ~rsp_good;
  wire idx_last = (idx_ff == LAST_IDX);
  wire fuse_wr = (st_ff == esm_pkg::ESM_ST_FUSE_WR);
  wire rem_wr = (st_ff == esm_pkg::ESM_ST_REM_WAIT) & rsp_good;
  wire copy_wr = fuse_wr | rem_wr;

  always_comb begin
    nxt_st = st_ff;
    nxt_mode = mode_ff;
    nxt_idx = idx_ff;
    nxt_wait = wait_ff;
    if (mode_chg) begin
      nxt_st = esm_pkg::ESM_ST_BOOT;
    end else begin
      unique case (st_ff)
        esm_pkg::ESM_ST_BOOT: begin
          if (boot_done) begin
            nxt_mode = sel_mode;
            nxt_idx = 8'h00;
            nxt_wait = 16'h0000;
            unique case (sel_mode)
              esm_pkg::ESM_SRC_FUSE: nxt_st = esm_pkg::ESM_ST_FUSE_RD;
              esm_pkg::ESM_SRC_REMOTE: nxt_st = esm_pkg::ESM_ST_REM_REQ;
              esm_pkg::ESM_SRC_LOCAL,
              esm_pkg::ESM_SRC_SRAM: nxt_st = esm_pkg::ESM_ST_READY;
            endcase
          end
        end
        esm_pkg::ESM_ST_FUSE_RD: begin
          nxt_st = esm_pkg::ESM_ST_FUSE_WR;
        end
        esm_pkg::ESM_ST_FUSE_WR: begin
          nxt_idx = idx_ff + 8'h01;
          nxt_st = idx_last ? esm_pkg::ESM_ST_READY : esm_pkg::ESM_ST_FUSE_RD;
        end
        esm_pkg::ESM_ST_REM_REQ: begin
          nxt_wait = 16'h0000;
          if (bc_req_ready_in) begin
            nxt_st = esm_pkg::ESM_ST_REM_WAIT;
          end
        end
        esm_pkg::ESM_ST_REM_WAIT: begin
          nxt_wait = wait_ff + 16'h0001;
          if (rsp_good) begin
            nxt_idx = idx_ff + 8'h01;
            nxt_st = idx_last ? esm_pkg::ESM_ST_READY : esm_pkg::ESM_ST_REM_REQ;
          end else if (rsp_bad || wait_ff == tmo_lim) begin
            nxt_wait = 16'h0000;
            nxt_st = esm_pkg::ESM_ST_REM_HOLD;
          end
        end
        esm_pkg::ESM_ST_REM_HOLD: begin
          nxt_wait = wait_ff + 16'h0001;
          if (wait_ff == hold_lim) begin
            nxt_st = esm_pkg::ESM_ST_REM_REQ;
          end
        end
        esm_pkg::ESM_ST_READY: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st_ff <= esm_pkg::ESM_ST_BOOT;
      mode_ff <= esm_pkg::ESM_SRC_LOCAL;
      idx_ff <= 8'h00;
      wait_ff <= 16'h0000;
    end else begin
      st_ff <= nxt_st;
      mode_ff <= nxt_mode;
      idx_ff <= nxt_idx;
      wait_ff <= nxt_wait;
    end
  end

  // store counts as loaded once the outside master says so; set beats clear
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      loaded_ff <= 1'b0;
    end else if (hst_load_done_in) begin
      loaded_ff <= 1'b1;
    end else if (st_ff == esm_pkg::ESM_ST_BOOT) begin
      loaded_ff <= 1'b0;
    end
  end

  // *****************************
  // store and DDC slave
  // *****************************
  esm_core_if core_if ();

  assign core_if.wr_en = copy_wr | hst_wr_in;
  assign core_if.wr_addr = copy_wr ? idx_ff : hst_addr_in;
  assign core_if.wr_data = fuse_wr ? fuse_data_in : (rem_wr ? bc_rsp_data_in : hst_wdata_in);
  assign core_if.hst_addr = hst_addr_in;
  assign core_if.scl = scl_lvl;
  assign core_if.sda = sda_lvl;
  assign core_if.match_any = is_local;
  assign core_if.slv_en = pwr_lvl & edid_ready_out;

  esm_edid_ram #(
    .DEPTH(256)
  ) u_ram (
    .sys_clk_in(sys_clk_in),
    .mem(core_if.ram)
  );

  esm_ddc_slave u_slave (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .bus(core_if.slv)
  );

  // *****************************
  // outputs
  // *****************************
  logic rvalid_ff;
  logic [3:0] gpio_ff;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rvalid_ff <= 1'b0;
      gpio_ff <= 4'h0;
    end else begin
      rvalid_ff <= hst_rd_in;
      if (bc_frm_valid_in && !bc_frm_crc_err_in) begin
        gpio_ff <= bc_frm_gpio_in;
      end
    end
  end

  wire sram_wait = (mode_ff == esm_pkg::ESM_SRC_SRAM) & ~loaded_ff;

  assign edid_ready_out = (st_ff == esm_pkg::ESM_ST_READY) & ~sram_wait;
  assign hpd_out = 1'b0;
  assign hpd_oe_out = ~(pwr_lvl & edid_ready_out);
  assign ddc_sda_out = 1'b0;
  // local mode: DDC and EEPROM bridged, direction taken from the tracked bus phase
  assign ddc_sda_oe_out = is_local ? (core_if.turn & ~eep_sda_lvl & core_if.slv_en)
                                   : core_if.sda_low;
  assign eep_scl_out = 1'b0;
  assign eep_scl_oe_out = is_local & core_if.slv_en & ~scl_lvl;
  assign eep_sda_out = 1'b0;
  assign eep_sda_oe_out = is_local & core_if.slv_en & ~core_if.turn & ~sda_lvl;
  assign hst_ready_out = ~copy_wr;
  assign hst_rdata_out = core_if.hst_data;
  assign hst_rvalid_out = rvalid_ff;
  assign fuse_addr_out = idx_ff;
  assign bc_req_valid_out = (st_ff == esm_pkg::ESM_ST_REM_REQ);
  assign bc_req_dev_out = `ESM_DDC_ADDR;
  assign bc_req_off_out = idx_ff;
  assign gpio_out = gpio_ff;
  assign src_mode_out = mode_ff;

endmodule : esm_edid_mgr

// ==== esm_edid_mgr_checker.sv ====
// esm_edid_mgr_checker.sv: port assertions for the EDID source manager
// assumes one sys_clk_in domain and a synchronous active-high rst_in
`timescale 1ns/1ps

module esm_edid_mgr_checker #(
  parameter int unsigned RETRY_CYC = 20
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic pwr5v_in,
  input wire logic hpd_out,
  input wire logic hpd_oe_out,
  input wire logic hst_rd_in,
  input wire logic hst_rvalid_out,
  input wire logic bc_req_valid_out,
  input wire logic bc_req_ready_in,
  input wire logic [7:0] bc_req_dev_out,
  input wire logic [7:0] bc_req_off_out,
  input wire logic bc_rsp_valid_in,
  input wire logic bc_rsp_nack_in,
  input wire logic bc_frm_valid_in,
  input wire logic bc_frm_crc_err_in,
  input wire logic [3:0] bc_frm_gpio_in,
  input wire logic [3:0] gpio_out,
  input wire logic edid_ready_out
);
  localparam int RW = RETRY_CYC + 8;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  // *****
  // sequences and properties
  // *****
  sequence s_rsp_good;
    bc_rsp_valid_in && !bc_rsp_nack_in && !bc_frm_crc_err_in && bc_req_off_out != 8'hFF;
  endsequence
  sequence s_rsp_bad;
    bc_rsp_valid_in && (bc_rsp_nack_in || bc_frm_crc_err_in);
  endsequence
  sequence s_hold_off;
    (!bc_req_valid_out) [*8];
  endsequence

  property p_hpd_rel;
    !hpd_oe_out |-> edid_ready_out && !hpd_out;
  endproperty
  property p_hpd_pwr;
    (!pwr5v_in) [*6] |-> hpd_oe_out;
  endproperty
  property p_rd_ans;
    hst_rd_in |=> hst_rvalid_out;
  endproperty
  property p_rv_only;
    hst_rvalid_out |-> $past(hst_rd_in);
  endproperty
  property p_bc_dev;
    bc_req_valid_out |-> bc_req_dev_out == 8'hA0;
  endproperty
  property p_bc_hold;
    bc_req_valid_out && !bc_req_ready_in |=> bc_req_valid_out && $stable(bc_req_off_out);
  endproperty
  property p_bc_next;
    s_rsp_good |=> bc_req_valid_out && bc_req_off_out == $past(bc_req_off_out) + 8'h01;
  endproperty
  property p_bc_retry;
    s_rsp_bad |=> s_hold_off ##[1:RW] bc_req_valid_out;
  endproperty
  property p_gpio;
    bc_frm_valid_in && !bc_frm_crc_err_in |=> gpio_out == $past(bc_frm_gpio_in);
  endproperty
  property p_gpio_bad;
    bc_frm_valid_in && bc_frm_crc_err_in |=> $stable(gpio_out);
  endproperty

  // *****
  // assertions
  // *****
  a_hpd_rel: assert property (p_hpd_rel) else $error("hot-plug released early");
  a_hpd_pwr: assert property (p_hpd_pwr) else $error("hot-plug released unpowered");
  a_rd_ans: assert property (p_rd_ans) else $error("store read not answered");
  a_rv_only: assert property (p_rv_only) else $error("stray read valid");
  a_bc_dev: assert property (p_bc_dev) else $error("remote device address wrong");
  a_bc_hold: assert property (p_bc_hold) else $error("request not held");
  a_bc_next: assert property (p_bc_next) else $error("next offset not requested");
  a_bc_retry: assert property (p_bc_retry) else $error("retry timing wrong");
  a_gpio: assert property (p_gpio) else $error("gpio not taken from frame");
  a_gpio_bad: assert property (p_gpio_bad) else $error("gpio taken from bad frame");
endmodule : esm_edid_mgr_checker

bind esm_edid_mgr esm_edid_mgr_checker #(.RETRY_CYC(RETRY_CYC)) u_chk (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .pwr5v_in(pwr5v_in), .hpd_out(hpd_out),
  .hpd_oe_out(hpd_oe_out), .hst_rd_in(hst_rd_in), .hst_rvalid_out(hst_rvalid_out),
  .bc_req_valid_out(bc_req_valid_out), .bc_req_ready_in(bc_req_ready_in),
  .bc_req_dev_out(bc_req_dev_out), .bc_req_off_out(bc_req_off_out),
  .bc_rsp_valid_in(bc_rsp_valid_in), .bc_rsp_nack_in(bc_rsp_nack_in),
  .bc_frm_valid_in(bc_frm_valid_in), .bc_frm_crc_err_in(bc_frm_crc_err_in),
  .bc_frm_gpio_in(bc_frm_gpio_in), .gpio_out(gpio_out), .edid_ready_out(edid_ready_out));

// ==== esm_ddc_src.sv ====
// esm_ddc_src.sv: video source model, +5 V supply and DDC master reads
// assumes sda_in is the wired level with a pull-up; only this model drives scl
`timescale 1ns/1ps

module esm_ddc_src (
  input wire logic sys_clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_oe_out,
  output logic pwr5v_out
);
  localparam int QTR = 30;
  logic [7:0] rd_q [4];
  logic addr_ack;

  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
    pwr5v_out = 1'b0;
  end

  // *****
  // bit level
  // *****
  task automatic qw(input logic scl, input logic oe);
    scl_out <= scl;
    sda_oe_out <= oe;
    repeat (QTR) @(posedge sys_clk_in);
  endtask : qw

  // scl falls before sda moves, so no false start or stop
  task automatic bit_io(input logic b, output logic r);
    qw(1'b0, sda_oe_out);
    qw(1'b0, ~b);
    qw(1'b1, ~b);
    r = sda_in;
    qw(1'b1, ~b);
  endtask : bit_io

  task automatic start();
    qw(1'b0, sda_oe_out);
    qw(1'b0, 1'b0);
    qw(1'b1, 1'b0);
    qw(1'b1, 1'b1);
  endtask : start

  task automatic stop();
    qw(1'b0, sda_oe_out);
    qw(1'b0, 1'b1);
    qw(1'b1, 1'b1);
    qw(1'b1, 1'b0);
  endtask : stop

  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, ack);
  endtask : wbyte

  // *****
  // source actions
  // *****
  task automatic power(input logic on);
    pwr5v_out <= on;
  endtask : power

  task automatic edid_read(input logic [7:0] dev, input logic [7:0] off, input int n);
    logic a;
    logic r;
    start();
    wbyte(dev, addr_ack);
    if (addr_ack == 1'b0) begin
      wbyte(off, a);
      start();
      wbyte(dev | 8'h01, a);
      for (int k = 0; k < n; k++) begin
        for (int i = 7; i >= 0; i--) begin
          bit_io(1'b1, r);
          rd_q[k][i] = r;
        end
        bit_io(k == n - 1, r);
      end
    end
    stop();
  endtask : edid_read
endmodule : esm_ddc_src

// ==== esm_tb.sv ====
// esm_tb.sv: self-checking bench for the EDID source manager
// assumes the design, its checker and the source model are compiled first
`timescale 1ns/1ps

module testbench;
  logic sys_clk_in = 1'b0, rst_in = 1'b1, pwr5v_in, ddc_scl_in, eep_sda_in = 1'b1;
  logic [1:0] src_strap_in = 2'h3, src_ovr_in = 2'h0;
  logic src_ovr_en_in = 1'b0, hst_wr_in = 1'b0, hst_rd_in = 1'b0, hst_load_done_in = 1'b0;
  logic [7:0] hst_addr_in = 8'h00, hst_wdata_in = 8'h00, fuse_data_in = 8'h00;
  logic bc_req_ready_in = 1'b0, bc_rsp_valid_in = 1'b0, bc_rsp_nack_in = 1'b0;
  logic [7:0] bc_rsp_data_in = 8'h00;
  logic bc_frm_valid_in = 1'b0, bc_frm_crc_err_in = 1'b0, bc_fast_in = 1'b0;
  logic [3:0] bc_frm_gpio_in = 4'h0;
  logic hpd_oe_out, ddc_sda_oe_out, hst_ready_out, hst_rvalid_out, bc_req_valid_out;
  logic edid_ready_out, src_sda_oe;
  logic [7:0] hst_rdata_out, fuse_addr_out, bc_req_dev_out, bc_req_off_out;
  logic [3:0] gpio_out;
  logic [1:0] src_mode_out;
  wire ddc_sda_in = ~(src_sda_oe | ddc_sda_oe_out);
  int bad_count = 0, comparisons = 0, rsp_wait = 0;
  logic [7:0] rsp_off = 8'h00;
  logic nacked = 1'b0;

  esm_edid_mgr #(.RETRY_CYC(20)) dut (.*, .hpd_out(), .ddc_sda_out(), .eep_scl_out(),
    .eep_scl_oe_out(), .eep_sda_out(), .eep_sda_oe_out());
  esm_ddc_src src (.sys_clk_in(sys_clk_in), .sda_in(ddc_sda_in), .scl_out(ddc_scl_in),
    .sda_oe_out(src_sda_oe), .pwr5v_out(pwr5v_in));

  always #5 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) fuse_data_in <= fuse_addr_out ^ 8'h5A;

  // *****
  // remote side: slow and prompt answers, one refusal at offset 0
  // *****
  always @(posedge sys_clk_in) begin
    bc_rsp_valid_in <= 1'b0;
    bc_rsp_data_in <= ~bc_rsp_data_in;
    bc_req_ready_in <= ~bc_req_ready_in;
    if (rsp_wait == 1) begin
      bc_rsp_valid_in <= 1'b1;
      bc_rsp_nack_in <= (rsp_off == 8'h00) && !nacked;
      nacked <= nacked | (rsp_off == 8'h00);
      bc_rsp_data_in <= ~rsp_off;
    end
    if (rsp_wait > 0) rsp_wait <= rsp_wait - 1;
    else if (bc_req_valid_out && bc_req_ready_in) begin
      rsp_wait <= 2 + int'(bc_req_off_out[1:0]);
      rsp_off <= bc_req_off_out;
    end
  end

  // *****
  // shared tasks
  // *****
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic test_done();
    if (bad_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  task automatic hcheck(input logic [7:0] a, input logic [7:0] exp);
    hst_rd_in <= 1'b1;
    hst_addr_in <= a;
    @(posedge sys_clk_in);
    hst_rd_in <= 1'b0;
    @(negedge sys_clk_in);
    chk("rvalid", 8'h01, {7'h00, hst_rvalid_out});
    chk("store", exp, hst_rdata_out);
    @(posedge sys_clk_in);
  endtask : hcheck

  task automatic set_mode(input logic [1:0] m);
    src_ovr_en_in <= 1'b1;
    src_ovr_in <= m;
    for (int n = 0; n < 50 && src_mode_out !== m; n++) @(posedge sys_clk_in);
    repeat (10) @(posedge sys_clk_in);
    chk("mode", {6'h00, m}, {6'h00, src_mode_out});
  endtask : set_mode

  task automatic wait_ready(input int lim);
    for (int n = 0; n < lim && edid_ready_out !== 1'b1; n++) @(posedge sys_clk_in);
    chk("edid_ready", 8'h01, {7'h00, edid_ready_out});
  endtask : wait_ready

  // *****
  // scenarios
  // *****
  task automatic t_reset();
    @(negedge sys_clk_in);
    chk("hpd_oe", 8'h01, {7'h00, hpd_oe_out});
    chk("edid_ready", 8'h00, {7'h00, edid_ready_out});
    chk("bc_valid", 8'h00, {7'h00, bc_req_valid_out});
    chk("gpio", 8'h00, {4'h0, gpio_out});
    @(posedge sys_clk_in);
  endtask : t_reset

  task automatic t_fuse();
    wait_ready(2000);
    chk("mode", 8'h03, {6'h00, src_mode_out});
    for (int i = 0; i < 256; i++) hcheck(8'(i), 8'(i) ^ 8'h5A);
    chk("hpd_oe", 8'h01, {7'h00, hpd_oe_out});
    src.power(1'b1);
    repeat (10) @(posedge sys_clk_in);
    chk("hpd_oe", 8'h00, {7'h00, hpd_oe_out});
    src.edid_read(8'hA0, 8'hFE, 3);
    chk("ddc_ack", 8'h00, {7'h00, src.addr_ack});
    for (int k = 0; k < 3; k++) chk("ddc", 8'(8'hFE + k) ^ 8'h5A, src.rd_q[k]);
    src.edid_read(8'hA4, 8'h00, 1);
    chk("ddc_ack", 8'h01, {7'h00, src.addr_ack});
  endtask : t_fuse

  task automatic t_sram();
    set_mode(2'h1);
    for (int i = 0; i < 256; i++) begin
      hst_wr_in <= 1'b1;
      hst_addr_in <= 8'(i);
      hst_wdata_in <= 8'(i) + 8'h33;
      @(posedge sys_clk_in);
    end
    hst_wr_in <= 1'b0;
    @(negedge sys_clk_in);
    chk("edid_ready", 8'h00, {7'h00, edid_ready_out});
    @(posedge sys_clk_in);
    hst_load_done_in <= 1'b1;
    @(posedge sys_clk_in);
    hst_load_done_in <= 1'b0;
    wait_ready(50);
    for (int i = 0; i < 256; i += 51) hcheck(8'(i), 8'(i) + 8'h33);
    src.edid_read(8'hA0, 8'hFF, 2);
    chk("ddc", 8'h32, src.rd_q[0]);
    chk("ddc", 8'h33, src.rd_q[1]);
  endtask : t_sram

  task automatic t_remote();
    set_mode(2'h2);
    wait_ready(6000);
    for (int i = 0; i < 256; i++) hcheck(8'(i), ~8'(i));
  endtask : t_remote

  task automatic t_gpio();
    bc_frm_valid_in <= 1'b1;
    bc_frm_gpio_in <= 4'hA;
    @(posedge sys_clk_in);
    bc_frm_gpio_in <= 4'h5;
    bc_frm_crc_err_in <= 1'b1;
    @(posedge sys_clk_in);
    bc_frm_valid_in <= 1'b0;
    bc_frm_crc_err_in <= 1'b0;
    bc_frm_gpio_in <= 4'h3;
    @(negedge sys_clk_in);
    chk("gpio", 8'h0A, {4'h0, gpio_out});
    @(posedge sys_clk_in);
    set_mode(2'h0);
  endtask : t_gpio

  initial begin
    repeat (4) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    @(posedge sys_clk_in);
    t_reset();
    t_fuse();
    t_sram();
    t_remote();
    t_gpio();
    test_done();
  end

  initial begin
    repeat (80000) @(posedge sys_clk_in);
    bad_count++;
    test_done();
  end
endmodule : testbench
